/* rtl/pseq_consts.vh */
// constants for the preset power-up sequencer and pin defaults
`ifndef PSEQ_CONSTS_VH
`define PSEQ_CONSTS_VH
// register offsets
`define PSEQ_CTRL_ADDR 8'h00
`define PSEQ_STATUS_ADDR 8'h04
`define PSEQ_SUPEN_ADDR 8'h08
`define PSEQ_GPIO_ADDR 8'h0C
`define PSEQ_SUPPLY_BASE 8'h10
`define PSEQ_PIN_BASE 8'h40
// control bits
`define PSEQ_CTRL_START 0
`define PSEQ_CTRL_STOP 1
// supply register fields
`define PSEQ_SLOT_LSB 10
`define PSEQ_CONV_VSEL_W 7
`define PSEQ_LREG_VSEL_W 5
`define PSEQ_SLOT_OFF 4'h0
`define PSEQ_SLOT_LAST 4'hE
`define PSEQ_SLOT_ACTIVE 4'hF
// preset start slots and voltage codes, supplies 0..3 converters, 4..7 linear
`define PSEQ_CONV1_SLOT 4'h1
`define PSEQ_CONV1_VSEL 7'h0E
`define PSEQ_CONV2_SLOT 4'h0
`define PSEQ_CONV2_VSEL 7'h00
`define PSEQ_CONV3_SLOT 4'h2
`define PSEQ_CONV3_VSEL 7'h26
`define PSEQ_CONV4_SLOT 4'h5
`define PSEQ_CONV4_VSEL 7'h62
`define PSEQ_LREG1_SLOT 4'h3
`define PSEQ_LREG1_VSEL 7'h06
`define PSEQ_LREG2_SLOT 4'h0
`define PSEQ_LREG2_VSEL 7'h16
`define PSEQ_LREG3_SLOT 4'h0
`define PSEQ_LREG3_VSEL 7'h19
`define PSEQ_LREG4_SLOT 4'h4
`define PSEQ_LREG4_VSEL 7'h1A
// pin register fields {debounce, pulldown, pullup, polarity, direction, function}
`define PSEQ_PIN_DIR 4
`define PSEQ_PIN_CFG 5
`define PSEQ_PIN_DB 8
`define PSEQ_PIN_DEF_IN 9'h130
`define PSEQ_PIN_DEF_0 9'h030
`define PSEQ_PIN_DEF_1 9'h111
`define PSEQ_PIN_DEF_2 9'h123
`define PSEQ_PIN_DEF_4 9'h171
`define PSEQ_PIN_DEF_10 9'h123
`define PSEQ_PIN_DEF_11 9'h132
`define PSEQ_PIN_DEF_12 9'h103
// function codes
`define PSEQ_FN_PWRON 4'h1
`define PSEQ_FN_MR 4'h1
`define PSEQ_FN_WAKE 4'h2
`define PSEQ_FN_ALT 4'h3
`define PSEQ_FN_LDOENA 4'h1
`define PSEQ_LDOENA_PIN 6
// timing
`define PSEQ_CLK_PERIOD_PS 10000
`define PSEQ_SLOT_TIME_US 1280
`endif

/* rtl/pseq_preset_sequencer.v */
// preset power-up sequencer with supply and pin default registers
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pseq_consts.vh"
module pseq_preset_sequencer #(
	parameter SLOT_CYCLES = (`PSEQ_SLOT_TIME_US * 1000000) / `PSEQ_CLK_PERIOD_PS
)(
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [31:0] wrData,
	input wire wrStrobe,
	input wire rdStrobe,
	output reg [31:0] rdData,
	input wire oscValid,
	input wire osc32kIn,
	input wire chargeActive,
	input wire lineSwitchOn,
	input wire [12:0] pinIn,
	output reg [12:0] pinOut,
	output reg [12:0] pinOe,
	output reg [7:0] supplyEnable,
	output reg [55:0] supplyVoltageCodes,
	output reg resetOutN
);
////////////////////////////////////////////////////////////////////////////////
// states and pin roles
localparam [3:0] ST_OFF = 4'b0001;
localparam [3:0] ST_WAITOSC = 4'b0010;
localparam [3:0] ST_SEQ = 4'b0100;
localparam [3:0] ST_ACTIVE = 4'b1000;
localparam [2:0] ROLE_GPIO = 3'd0;
localparam [2:0] ROLE_PWRON = 3'd1;
localparam [2:0] ROLE_MR = 3'd2;
localparam [2:0] ROLE_WAKE = 3'd3;
localparam [2:0] ROLE_CHIND = 3'd4;
localparam [2:0] ROLE_LINESW = 3'd5;
localparam [2:0] ROLE_CLK32 = 3'd6;
localparam [2:0] ROLE_LDOENA = 3'd7;
////////////////////////////////////////////////////////////////////////////////
// decoding functions
function [2:0] pinRole;
	input integer idx;
	input [3:0] fn;
	begin
		pinRole = ROLE_GPIO;
		if ((idx == 1 || idx == 3) && fn == `PSEQ_FN_PWRON)
			pinRole = ROLE_PWRON;
		if (idx == 4 && fn == `PSEQ_FN_MR)
			pinRole = ROLE_MR;
		if (idx == 11 && fn == `PSEQ_FN_WAKE)
			pinRole = ROLE_WAKE;
		if (idx == 10 && fn == `PSEQ_FN_ALT)
			pinRole = ROLE_CHIND;
		if (idx == 12 && fn == `PSEQ_FN_ALT)
			pinRole = ROLE_LINESW;
		if (idx == 2 && fn == `PSEQ_FN_ALT)
			pinRole = ROLE_CLK32;
		if (idx == `PSEQ_LDOENA_PIN && fn == `PSEQ_FN_LDOENA)
			pinRole = ROLE_LDOENA;
	end
endfunction

function [10:0] supplyDefault;
	input integer idx;
	begin
		case (idx)
			0: supplyDefault = {`PSEQ_CONV1_SLOT, `PSEQ_CONV1_VSEL};
			1: supplyDefault = {`PSEQ_CONV2_SLOT, `PSEQ_CONV2_VSEL};
			2: supplyDefault = {`PSEQ_CONV3_SLOT, `PSEQ_CONV3_VSEL};
			3: supplyDefault = {`PSEQ_CONV4_SLOT, `PSEQ_CONV4_VSEL};
			4: supplyDefault = {`PSEQ_LREG1_SLOT, `PSEQ_LREG1_VSEL};
			5: supplyDefault = {`PSEQ_LREG2_SLOT, `PSEQ_LREG2_VSEL};
			6: supplyDefault = {`PSEQ_LREG3_SLOT, `PSEQ_LREG3_VSEL};
			default: supplyDefault = {`PSEQ_LREG4_SLOT, `PSEQ_LREG4_VSEL};
		endcase
	end
endfunction

function [8:0] pinDefault;
	input integer idx;
	begin
		case (idx)
			0: pinDefault = `PSEQ_PIN_DEF_0;
			1: pinDefault = `PSEQ_PIN_DEF_1;
			2: pinDefault = `PSEQ_PIN_DEF_2;
			4: pinDefault = `PSEQ_PIN_DEF_4;
			10: pinDefault = `PSEQ_PIN_DEF_10;
			11: pinDefault = `PSEQ_PIN_DEF_11;
			12: pinDefault = `PSEQ_PIN_DEF_12;
			default: pinDefault = `PSEQ_PIN_DEF_IN;
		endcase
	end
endfunction
////////////////////////////////////////////////////////////////////////////////
// synchronisers and simple debounce
reg [15:0] syncA_q;
reg [15:0] syncB_q;
reg [12:0] pinPrev_q;
reg [12:0] pinLevel_q;
wire [12:0] pinSync = syncB_q[12:0];
wire oscValidSync = syncB_q[13];
wire chargeSync = syncB_q[14];
wire lineSwSync = syncB_q[15];
reg osc32kA_q;
reg osc32kB_q;
wire [8:0] pinCfg [0:12];
reg [12:0] pinFilt_q;
wire [12:0] pinValue;

always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		// pin path starts at the pulled-up idle level, so no false press follows reset
		syncA_q <= 16'h1FFF;
		syncB_q <= 16'h1FFF;
		osc32kA_q <= 1'b0;
		osc32kB_q <= 1'b0;
		pinPrev_q <= 13'h1FFF;
		pinLevel_q <= 13'h1FFF;
	end
	else
	begin
		syncA_q <= {lineSwitchOn, chargeActive, oscValid, pinIn};
		syncB_q <= syncA_q;
		osc32kA_q <= osc32kIn;
		osc32kB_q <= osc32kA_q;
		pinPrev_q <= pinSync;
		pinLevel_q <= pinFilt_q;
	end
end
////////////////////////////////////////////////////////////////////////////////
// configuration registers
reg [3:0] slotCode_q [0:7];
reg [6:0] vsel_q [0:7];
reg [8:0] pinCfg_q [0:12];
reg [12:0] gpioOut_q;
wire wrSupply = wrStrobe && addr >= `PSEQ_SUPPLY_BASE && addr < 8'h30 && addr[1:0] == 2'b00;
wire wrPin = wrStrobe && addr >= `PSEQ_PIN_BASE && addr < 8'h74 && addr[1:0] == 2'b00;
wire [2:0] supplyIdx = {~addr[4], addr[3:2]};
wire [3:0] pinIdx = addr[5:2] - 4'h0;
wire [12:0] pinAsserted;
wire [12:0] roleMr;
wire [12:0] rolePwr;
wire [12:0] roleLdo;

genvar g;
generate
	for (g = 0; g < 8; g = g + 1)
	begin : gSupply
		localparam [10:0] SUP_DEF = supplyDefault(g);
		always @(posedge clk or posedge rst)
		begin
			if (rst)
			begin
				slotCode_q[g] <= SUP_DEF[10:7];
				vsel_q[g] <= SUP_DEF[6:0];
			end
			else if (wrSupply && supplyIdx == g)
			begin
				slotCode_q[g] <= wrData[`PSEQ_SLOT_LSB+3:`PSEQ_SLOT_LSB];
				if (g < 4)
					vsel_q[g] <= wrData[6:0];
				else
					vsel_q[g] <= {2'b00, wrData[4:0]};
			end
		end
	end
	for (g = 0; g < 13; g = g + 1)
	begin : gPin
		wire [2:0] role = pinRole(g, pinCfg_q[g][3:0]);
		wire invRole = role == ROLE_MR || role == ROLE_WAKE || role == ROLE_LDOENA;
		wire activeLow = invRole ? pinCfg_q[g][`PSEQ_PIN_CFG] : ~pinCfg_q[g][`PSEQ_PIN_CFG];
		assign pinCfg[g] = pinCfg_q[g];
		assign pinAsserted[g] = pinCfg_q[g][`PSEQ_PIN_DIR] & (pinLevel_q[g] ^ activeLow);
		assign roleMr[g] = role == ROLE_MR;
		assign rolePwr[g] = role == ROLE_PWRON || role == ROLE_WAKE;
		assign roleLdo[g] = role == ROLE_LDOENA;
		always @(posedge clk or posedge rst)
		begin
			if (rst)
				pinCfg_q[g] <= pinDefault(g);
			else if (wrPin && pinIdx == g)
				pinCfg_q[g] <= wrData[8:0];
		end
		// debounced pins follow only two agreeing samples
		always @(posedge clk or posedge rst)
		begin
			if (rst)
				pinFilt_q[g] <= 1'b1;
			else if (!pinCfg_q[g][`PSEQ_PIN_DB] || pinSync[g] == pinPrev_q[g])
				pinFilt_q[g] <= pinSync[g];
		end
		// output drive, polarity bit picks open drain on outputs
		always @(posedge clk or posedge rst)
		begin
			if (rst)
			begin
				pinOut[g] <= 1'b0;
				pinOe[g] <= 1'b0;
			end
			else if (pinCfg_q[g][`PSEQ_PIN_DIR])
			begin
				pinOut[g] <= 1'b0;
				pinOe[g] <= 1'b0;
			end
			else
			begin
				pinOut[g] <= pinCfg_q[g][`PSEQ_PIN_CFG] ? 1'b0 : pinValue[g];
				pinOe[g] <= pinCfg_q[g][`PSEQ_PIN_CFG] ? ~pinValue[g] : 1'b1;
			end
		end
		assign pinValue[g] = role == ROLE_CHIND ? chargeSync :
			role == ROLE_LINESW ? lineSwSync :
			role == ROLE_CLK32 ? osc32kB_q : gpioOut_q[g];
	end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// start-up sequencer
reg [3:0] state_q;
reg [3:0] slot_q;
reg [16:0] slotTimer_q;
reg slotTick_q;
wire mrActive = |(pinAsserted & roleMr);
wire pwrReq = |(pinAsserted & rolePwr);
wire ldoEnaReq = |(pinAsserted & roleLdo);
wire ctrlStart = wrStrobe && addr == `PSEQ_CTRL_ADDR && wrData[`PSEQ_CTRL_START];
wire ctrlStop = wrStrobe && addr == `PSEQ_CTRL_ADDR && wrData[`PSEQ_CTRL_STOP];
reg [7:0] slotMatch;
reg [7:0] activeMatch;
integer i;
integer j;

always @*
begin
	for (i = 0; i < 8; i = i + 1)
	begin
		slotMatch[i] = slotCode_q[i] == slot_q && slot_q != `PSEQ_SLOT_OFF;
		activeMatch[i] = slotCode_q[i] == `PSEQ_SLOT_ACTIVE;
	end
end

// slot divider gives a one-cycle tick per slot interval
always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		slotTimer_q <= 17'h00000;
		slotTick_q <= 1'b0;
	end
	else if (state_q != ST_SEQ)
	begin
		// preload one so the first slot lasts as long as the others
		slotTimer_q <= 17'h00001;
		slotTick_q <= 1'b0;
	end
	else if ({15'h0000, slotTimer_q} == SLOT_CYCLES - 1)
	begin
		slotTimer_q <= 17'h00000;
		slotTick_q <= 1'b1;
	end
	else
	begin
		slotTimer_q <= slotTimer_q + 17'h00001;
		slotTick_q <= 1'b0;
	end
end

always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		state_q <= ST_OFF;
		slot_q <= `PSEQ_SLOT_OFF;
		supplyEnable <= 8'h00;
	end
	else if (mrActive || ctrlStop)
	begin
		state_q <= ST_OFF;
		slot_q <= `PSEQ_SLOT_OFF;
		supplyEnable <= 8'h00;
	end
	else
	begin
		case (state_q)
			ST_OFF:
				if (pwrReq || ctrlStart)
					state_q <= ST_WAITOSC;
			ST_WAITOSC:
				if (oscValidSync)
				begin
					state_q <= ST_SEQ;
					slot_q <= 4'h1;
				end
			ST_SEQ:
			begin
				supplyEnable <= supplyEnable | slotMatch;
				if (slotTick_q)
				begin
					if (slot_q == `PSEQ_SLOT_LAST)
					begin
						state_q <= ST_ACTIVE;
						slot_q <= `PSEQ_SLOT_ACTIVE;
						supplyEnable <= supplyEnable | slotMatch | activeMatch;
					end
					else
						slot_q <= slot_q + 4'h1;
				end
			end
			ST_ACTIVE:
				if (wrStrobe && addr == `PSEQ_SUPEN_ADDR)
					supplyEnable <= wrData[7:0];
				else if (ldoEnaReq)
					supplyEnable[4] <= 1'b1;
			default:
				state_q <= ST_OFF;
		endcase
	end
end

// reset output follows the active state, a valid 32 kHz oscillator and a released MR pin
always @(posedge clk or posedge rst)
begin
	if (rst)
		resetOutN <= 1'b0;
	else
		resetOutN <= state_q == ST_ACTIVE && oscValidSync && !mrActive;
end
////////////////////////////////////////////////////////////////////////////////
// register port
wire wrSupplyRange = addr >= `PSEQ_SUPPLY_BASE && addr < 8'h30 && addr[1:0] == 2'b00;
wire wrPinRange = addr >= `PSEQ_PIN_BASE && addr < 8'h74 && addr[1:0] == 2'b00;

always @(posedge clk or posedge rst)
begin
	if (rst)
	begin
		gpioOut_q <= 13'h0000;
		rdData <= 32'h00000000;
		supplyVoltageCodes <= 56'h00000000000000;
	end
	else
	begin
		if (wrStrobe && addr == `PSEQ_GPIO_ADDR)
			gpioOut_q <= wrData[12:0];
		for (j = 0; j < 8; j = j + 1)
			supplyVoltageCodes[j*7 +: 7] <= vsel_q[j];
		rdData <= 32'h00000000;
		if (rdStrobe)
		begin
			if (addr == `PSEQ_STATUS_ADDR)
				rdData <= {23'h000000, oscValidSync, slot_q, state_q};
			else if (addr == `PSEQ_SUPEN_ADDR)
				rdData <= {24'h000000, supplyEnable};
			else if (addr == `PSEQ_GPIO_ADDR)
				rdData <= {19'h00000, pinFilt_q};
			else if (wrSupplyRange)
				rdData <= {18'h00000, slotCode_q[supplyIdx], 3'b000, vsel_q[supplyIdx]};
			else if (wrPinRange)
				rdData <= {23'h000000, pinCfg[pinIdx]};
		end
	end
end

endmodule // pseq_preset_sequencer
`default_nettype wire

/* tb/pmpud_properties.sv */
// assertion checker for the preset power-up sequencer
`timescale 1ns/1ps
`default_nettype none
module pmpud_checker #(
	parameter int SLOT_CYCLES = 20
)(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire logic [31:0] rdData,
	input wire logic oscValid,
	input wire logic osc32kIn,
	input wire logic chargeActive,
	input wire logic lineSwitchOn,
	input wire logic [12:0] pinIn,
	input wire logic [12:0] pinOut,
	input wire logic [12:0] pinOe,
	input wire logic [7:0] supplyEnable,
	input wire logic [55:0] supplyVoltageCodes,
	input wire logic resetOutN
);
	localparam logic [55:0] PRESET = {7'h1A, 7'h19, 7'h16, 7'h06, 7'h62, 7'h26, 7'h00, 7'h0E};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////
	a_preset_codes: assert property (
		!$past(rst) |-> supplyVoltageCodes == PRESET) else $error("voltage codes off preset");
	a_unused_off: assert property (
		(supplyEnable & 8'h62) == 8'h00) else $error("unsequenced supply enabled");
	a_order_mid: assert property (
		$rose(supplyEnable[2]) |-> supplyEnable[0]) else $error("converter 3 before 1");
	a_order_late: assert property (
		$rose(supplyEnable[3]) |-> &{supplyEnable[7], supplyEnable[4]}) else $error("bad order");
	a_slot_spacing: assert property (
		$rose(supplyEnable[0]) |-> ##SLOT_CYCLES $rose(supplyEnable[2])) else $error("slot gap");
	a_reset_osc: assert property (
		resetOutN |-> oscValid && $past(oscValid, 2)) else $error("reset released early");
	a_open_drain: assert property (
		!pinOut[10]) else $error("pin 10 drives high");
	a_mr_clears: assert property (
		(!pinIn[4]) [*8] |-> ##2 (supplyEnable == 8'h00 && !resetOutN)) else $error("mr ignored");
	c_active: cover property ($rose(resetOutN));
	c_last_slot: cover property ($rose(supplyEnable[3]));
	c_mr_off: cover property ($fell(resetOutN));
endmodule // pmpud_checker
////////////////////////////////////////
bind pseq_preset_sequencer pmpud_checker #(.SLOT_CYCLES(SLOT_CYCLES)) chkU (.clk(clk), .rst(rst),
	.addr(addr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
	.oscValid(oscValid), .osc32kIn(osc32kIn), .chargeActive(chargeActive),
	.lineSwitchOn(lineSwitchOn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
	.supplyEnable(supplyEnable), .supplyVoltageCodes(supplyVoltageCodes), .resetOutN(resetOutN));
`default_nettype wire

/* tb/pmpud_partner.sv */
// oscillator and host control pin model
`timescale 1ns/1ps
`default_nettype none
module pmpud_partner (
	input wire logic clk,
	input wire logic rst,
	input wire logic oscGo,
	input wire logic mrPress,
	input wire logic wakePress,
	output logic oscValid,
	output logic osc32kIn,
	output logic [12:0] pinIn
);
	logic [3:0] cnt_q;
	logic valid_q;
	// oscillator settles some cycles after start, then toggles
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= 4'h0;
			valid_q <= 1'b0;
		end
		else if (oscGo)
		begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == 4'hF)
				valid_q <= 1'b1;
		end
	end
	assign oscValid = valid_q;
	assign osc32kIn = valid_q & cnt_q[3];
	// lines idle high through pull-ups, buttons pull low
	assign pinIn = 13'h1FFF ^ {1'b0, wakePress, 6'h00, mrPress, 4'h0};
endmodule // pmpud_partner
`default_nettype wire

/* tb/test_preset_mode_power_up_defaults.sv */
// self-checking bench for the preset power-up sequencer
`timescale 1ns/1ps
`default_nettype none
module test_preset_mode_power_up_defaults;
	localparam int SC = 20;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wrData = 32'h0;
	logic wrStrobe = 1'b0;
	logic rdStrobe = 1'b0;
	logic chargeActive = 1'b0;
	logic lineSwitchOn = 1'b0;
	logic oscGo = 1'b0;
	logic mrPress = 1'b0;
	logic wakePress = 1'b0;
	logic b;
	logic [31:0] d;
	wire [31:0] rdData;
	wire oscValid;
	wire osc32kIn;
	wire [12:0] pinIn;
	wire [12:0] pinOut;
	wire [12:0] pinOe;
	wire [7:0] supplyEnable;
	wire [55:0] supplyVoltageCodes;
	wire resetOutN;
	int mismatches = 0;
	int compares = 0;
	int n;
	logic [3:0] sl [0:7] = '{4'h1, 4'h0, 4'h2, 4'h5, 4'h3, 4'h0, 4'h0, 4'h4};
	logic [6:0] vs [0:7] = '{7'h0E, 7'h00, 7'h26, 7'h62, 7'h06, 7'h16, 7'h19, 7'h1A};
	logic [7:0] pn [0:3] = '{8'h50, 8'h68, 8'h6C, 8'h70};
	logic [8:0] pe [0:3] = '{9'h171, 9'h123, 9'h132, 9'h103};
	logic [7:0] en [0:4] = '{8'h01, 8'h05, 8'h15, 8'h95, 8'h9D};
	always #5 clk = ~clk;
	pseq_preset_sequencer #(.SLOT_CYCLES(SC)) dut_u (.clk(clk), .rst(rst), .addr(addr),
		.wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
		.oscValid(oscValid), .osc32kIn(osc32kIn), .chargeActive(chargeActive),
		.lineSwitchOn(lineSwitchOn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.supplyEnable(supplyEnable), .supplyVoltageCodes(supplyVoltageCodes),
		.resetOutN(resetOutN));
	pmpud_partner part_u (.clk(clk), .rst(rst), .oscGo(oscGo), .mrPress(mrPress),
		.wakePress(wakePress), .oscValid(oscValid), .osc32kIn(osc32kIn), .pinIn(pinIn));
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic results;
		$display("mismatches %0d compares %0d", mismatches, compares);
		if (mismatches == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wrData <= v;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		d = rdData;
	endtask
	// waits for enables (sel 0) or reset output (sel 1) to reach e
	task automatic waitFor(input logic sel, input logic [7:0] e);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while ((sel ? {7'h00, resetOutN} : supplyEnable) !== e && n < 400);
		if (n >= 400)
		begin
			mismatches++;
			results;
		end
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			rd(8'h10 + 8'(4 * i));
			chk(d, {18'h0, sl[i], 3'h0, vs[i]});
		end
		for (int i = 0; i < 4; i++)
		begin
			rd(pn[i]);
			chk(d, {23'h0, pe[i]});
		end
		rd(8'h80);
		chk(d, 32'h0);
		wr(8'h00, 32'h1);
		repeat (30) @(posedge clk);
		rd(8'h04);
		chk(d & 32'h10F, 32'h2);
		chk({23'h0, resetOutN, supplyEnable}, 32'h0);
		@(posedge clk);
		oscGo <= 1'b1;
		for (int k = 0; k < 5; k++)
		begin
			waitFor(1'b0, en[k]);
			if (k > 0)
				chk(n, SC);
		end
		waitFor(1'b1, 8'h01);
		rd(8'h04);
		chk(d & 32'hF, 32'h8);
		chk({24'h0, supplyEnable}, 32'h9D);
		b = 1'b0;
		repeat (2)
		begin
			@(posedge clk);
			chargeActive <= b;
			lineSwitchOn <= b;
			repeat (8) @(posedge clk);
			#1;
			chk({pinOe[12], pinOut[12], pinOe[10], pinOut[10]}, {28'h0, 1'b1, b, ~b, 1'b0});
			b = ~b;
		end
		@(posedge clk);
		mrPress <= 1'b1;
		waitFor(1'b1, 8'h00);
		rd(8'h04);
		chk({d[3:0], supplyEnable}, 32'h100);
		@(posedge clk);
		mrPress <= 1'b0;
		repeat (10) @(posedge clk);
		wakePress <= 1'b1;
		waitFor(1'b0, 8'h01);
		chk({24'h0, supplyEnable}, 32'h01);
		@(posedge clk);
		wakePress <= 1'b0;
		results;
	end
endmodule // test_preset_mode_power_up_defaults
`default_nettype wire
